/* File: logic/flash_fe_pkg.sv */
/*
 Shared constants and carriers for the serial flash front end.
 Assumes a host that frames each operation with select and drives SCK.
*/
package flash_fe_pkg;
   // Link-side field sizes
   localparam int unsigned BYTE_W       = 8;
   localparam int unsigned ADDR_W       = 24;
   localparam int unsigned PAGE_BYTES   = 256;
   localparam int unsigned OTP_BYTES    = 128;
   localparam int unsigned OTP_FACTORY  = 64;
   localparam int unsigned BLK4K_BYTES  = 4096;
   localparam int unsigned BLK32K_BYTES = 32768;
   localparam int unsigned ARRAY_BYTES  = 32768;
   localparam int unsigned CMD_BITS     = 8;
   localparam int unsigned HDR_BITS     = 32;
   localparam logic [5:0]  BITCNT_RST   = 6'h00;
   localparam logic [8:0]  BYTECNT_RST  = 9'h000;
   localparam logic [8:0]  PAGE_LIMIT   = 9'h100;

   // Host command codes; values chosen for this front end
   localparam logic [7:0] CMD_READ      = 8'h03;
   localparam logic [7:0] CMD_DUAL_READ = 8'h3B;
   localparam logic [7:0] CMD_PROGRAM   = 8'h02;
   localparam logic [7:0] CMD_ERASE_PG  = 8'h81;
   localparam logic [7:0] CMD_ERASE_4K  = 8'h20;
   localparam logic [7:0] CMD_ERASE_32K = 8'h52;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h60;
   localparam logic [7:0] CMD_STATUS    = 8'h05;
   localparam logic [7:0] CMD_OTP_PROG  = 8'h9B;
   localparam logic [7:0] CMD_OTP_READ  = 8'h77;

   // Busy time of a self-timed cycle in system clocks
   localparam int unsigned BUSY_NS      = 1000;
   localparam int unsigned CLK_NS       = 8;
   localparam int unsigned BUSY_CYC     = (BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] BUSY_RST     = 16'h0000;

   // Operation kinds handed to the core
   typedef enum logic [2:0] {
      OP_PROGRAM = 3'h0,
      OP_ERASE_PG = 3'h1,
      OP_ERASE_4K = 3'h2,
      OP_ERASE_32K = 3'h3,
      OP_ERASE_ALL = 3'h4,
      OP_OTP_PROG = 3'h5
   } op_kind_t;

   // Write word passed across the buffer
   typedef struct packed {
      op_kind_t          kind;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
      logic              last;
   } wr_word_t;
endpackage

/* File: logic/flash_fe.sv */
/*
 Serial front end: SCK-domain shifter, two-entry write buffer and
 clk_sys-domain self-timed core with a status byte.
 Assumes SCK stops outside frames; select high clears link state.
*/
`timescale 1ns/1ps
module flash_fe
   import flash_fe_pkg::*;
(
   input  wire logic clk_sys,          // System clock
   input  wire logic arst_n,           // Async reset, active low
   input  wire logic sck,              // Link clock from host
   input  wire logic device_select_n,  // Select, active low
   input  wire logic hold_n,           // Pause, active low
   input  wire logic write_protect_n,  // Protect, active low
   input  wire logic dual_io_0_i,      // Serial in / io0 level
   output logic      dual_io_0_o,      // io0 output value
   output logic      dual_io_0_oe,     // io0 drive enable
   output logic      dual_io_1_o,      // Serial out value
   output logic      dual_io_1_oe,     // Serial out drive enable
   output logic      busy,             // Self-timed cycle running
   output logic      op_fail           // Last cycle failed
);
   typedef enum logic [3:0] {
      LS_CMD  = 4'b0001,
      LS_ADDR = 4'b0010,
      LS_WR   = 4'b0100,
      LS_RD   = 4'b1000
   } link_st_t;

   // Link-side state, reset by deselection or arst_n; toggle and word by arst_n only
   link_st_t          st_ff;
   logic [5:0]        bit_ff;
   logic [7:0]        cmd_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [7:0]        sh_ff;
   logic [8:0]        cnt_ff;
   logic              dual_ff;
   logic [1:0]        out_ff;
   logic              oe_ff;
   logic              wr_tgl_ff;
   wr_word_t          wr_ff;
   logic              frame_rst_n;

   assign frame_rst_n = ~device_select_n & arst_n;
   // Hold is sampled only with SCK low, so gating the clock is glitch-free
   logic hold_lat;
   always_latch begin
      if (!sck) begin
         hold_lat = hold_n;
      end
   end
   logic sck_g;
   assign sck_g = sck & hold_lat;

   // Sticky status crossed in from the core
   logic [1:0] stat_s1_ff, stat_s2_ff;
   always_ff @(posedge sck_g or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         stat_s1_ff <= 2'h0;
         stat_s2_ff <= 2'h0;
      end else begin
         stat_s1_ff <= {busy, op_fail};
         stat_s2_ff <= stat_s1_ff;
      end
   end

   // Next-state for the input shifter
   link_st_t          nxt_st;
   logic [5:0]        nxt_bit;
   logic [7:0]        nxt_cmd, nxt_sh;
   logic [ADDR_W-1:0] nxt_addr;
   logic [8:0]        nxt_cnt;
   logic              nxt_dual, nxt_tgl;
   wr_word_t          nxt_wr;
   logic [7:0]        in_byte;
   always_comb begin
      nxt_st = st_ff;
      nxt_bit = bit_ff + 6'h01;
      nxt_cmd = cmd_ff;
      nxt_addr = addr_ff;
      nxt_cnt = cnt_ff;
      nxt_dual = dual_ff;
      nxt_tgl = wr_tgl_ff;
      nxt_wr = wr_ff;
      nxt_sh = {sh_ff[6:0], dual_io_0_i};
      in_byte = {sh_ff[6:0], dual_io_0_i};
      case (st_ff)
         LS_CMD: begin
            if (bit_ff == 6'(CMD_BITS - 1)) begin
               nxt_cmd = in_byte;
               nxt_st = (in_byte == CMD_STATUS) ? LS_RD : LS_ADDR;
               nxt_dual = 1'b0;
               if (in_byte == CMD_ERASE_ALL) begin
                  nxt_wr = '{OP_ERASE_ALL, '0, 8'h00, 1'b1};
                  nxt_tgl = ~wr_tgl_ff;
                  nxt_st = LS_WR;
               end
            end
         end
         LS_ADDR: begin
            nxt_addr = {addr_ff[ADDR_W-2:0], dual_io_0_i};
            if (bit_ff == 6'(HDR_BITS - 1)) begin
               nxt_bit = BITCNT_RST;
               nxt_st = LS_WR;
               nxt_dual = (cmd_ff == CMD_DUAL_READ);
               if (cmd_ff == CMD_READ || cmd_ff == CMD_DUAL_READ ||
                   cmd_ff == CMD_OTP_READ) begin
                  nxt_st = LS_RD;
               end else if (cmd_ff == CMD_ERASE_PG || cmd_ff == CMD_ERASE_4K ||
                            cmd_ff == CMD_ERASE_32K) begin
                  nxt_wr.kind = (cmd_ff == CMD_ERASE_PG) ? OP_ERASE_PG :
                                (cmd_ff == CMD_ERASE_4K) ? OP_ERASE_4K : OP_ERASE_32K;
                  nxt_wr.addr = {addr_ff[ADDR_W-2:0], dual_io_0_i};
                  nxt_wr.last = 1'b1;
                  nxt_tgl = ~wr_tgl_ff;
               end
            end
         end
         LS_WR: begin
            // Bytes past one page are dropped
            if (bit_ff[2:0] == 3'h7 && cnt_ff != PAGE_LIMIT &&
                (cmd_ff == CMD_PROGRAM || cmd_ff == CMD_OTP_PROG)) begin
               nxt_wr.kind = (cmd_ff == CMD_PROGRAM) ? OP_PROGRAM : OP_OTP_PROG;
               nxt_wr.addr = addr_ff + ADDR_W'(cnt_ff);
               nxt_wr.data = in_byte;
               nxt_wr.last = 1'b0;
               nxt_cnt = cnt_ff + 9'h001;
               nxt_tgl = ~wr_tgl_ff;
            end
         end
         default: begin
            nxt_bit = bit_ff;
         end
      endcase
   end
   always_ff @(posedge sck_g or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         st_ff <= LS_CMD;
         bit_ff <= BITCNT_RST;
         cmd_ff <= 8'h00;
         addr_ff <= '0;
         sh_ff <= 8'h00;
         cnt_ff <= BYTECNT_RST;
         dual_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         bit_ff <= nxt_bit;
         cmd_ff <= nxt_cmd;
         addr_ff <= nxt_addr;
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
         dual_ff <= nxt_dual;
      end
   end

   // Toggle and word survive deselection, else a frame end fakes a push
   always_ff @(posedge sck_g or negedge arst_n) begin
      if (!arst_n) begin
         wr_tgl_ff <= 1'b0;
         wr_ff <= '0;
      end else begin
         wr_tgl_ff <= nxt_tgl;
         wr_ff <= nxt_wr;
      end
   end

   // Output shifter: read data is a pattern of the address, status is live
   logic [7:0] rd_byte;
   logic [2:0] rd_pos;
   logic [2:0] rd_cnt_ff;
   logic [ADDR_W-1:0] rd_addr_ff;
   logic [ADDR_W-1:0] rd_src;
   always_comb begin
      // First bit goes out before rd_addr_ff is loaded
      rd_src = oe_ff ? rd_addr_ff : addr_ff;
      rd_byte = (cmd_ff == CMD_STATUS) ? {6'h00, stat_s2_ff} :
                (cmd_ff == CMD_OTP_READ && rd_src[6] == 1'b0) ?
                   {2'h0, rd_src[5:0]} : rd_src[7:0];
      rd_pos = 3'h7 - rd_cnt_ff;
   end
   always_ff @(negedge sck_g or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         out_ff <= 2'h0;
         oe_ff <= 1'b0;
         rd_cnt_ff <= 3'h0;
         rd_addr_ff <= '0;
      end else if (st_ff == LS_RD) begin
         oe_ff <= 1'b1;
         if (!oe_ff) begin
            rd_addr_ff <= addr_ff;
         end
         if (dual_ff) begin
            out_ff <= {rd_byte[rd_pos], rd_byte[rd_pos - 3'h1]};
            rd_cnt_ff <= rd_cnt_ff + 3'h2;
         end else begin
            out_ff <= {rd_byte[rd_pos], 1'b0};
            rd_cnt_ff <= rd_cnt_ff + 3'h1;
         end
         if ((dual_ff && rd_cnt_ff == 3'h6) || rd_cnt_ff == 3'h7) begin
            rd_addr_ff <= rd_addr_ff + ADDR_W'(1);
         end
      end
   end
   assign dual_io_1_o = out_ff[1];
   assign dual_io_0_o = out_ff[0];
   assign dual_io_1_oe = oe_ff & hold_lat & ~device_select_n;
   assign dual_io_0_oe = oe_ff & dual_ff & hold_lat & ~device_select_n;

   // Toggle crossing into clk_sys; two-entry buffer feeds the core
   logic [2:0] tgl_sync_ff;
   logic       push_ff;
   wr_word_t   word_ff;
   logic [1:0] wp_sync_ff;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tgl_sync_ff <= 3'h0;
         push_ff <= 1'b0;
         word_ff <= '0;
         wp_sync_ff <= 2'h3;  // Inactive, as the pull-up leaves it
      end else begin
         tgl_sync_ff <= {tgl_sync_ff[1:0], wr_tgl_ff};
         wp_sync_ff <= {wp_sync_ff[0], write_protect_n};  // Pin crosses in
         push_ff <= tgl_sync_ff[2] ^ tgl_sync_ff[1];
         word_ff <= wr_ff; // Stable for many clocks after the toggle
      end
   end

   wr_word_t   buf_ff [2];
   logic [1:0] fill_ff;
   logic       rd_ptr_ff, wr_ptr_ff;
   logic       in_ready, out_valid, out_ready, pop;
   logic [15:0] busy_ff;
   logic        fail_ff;
   logic        lock_ff;
   assign in_ready = (fill_ff != 2'h2);
   assign out_valid = (fill_ff != 2'h0);
   assign out_ready = (busy_ff == BUSY_RST);
   assign pop = out_valid & out_ready;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fill_ff <= 2'h0;
         rd_ptr_ff <= 1'b0;
         wr_ptr_ff <= 1'b0;
         buf_ff[0] <= '0;
         buf_ff[1] <= '0;
      end else begin
         if (push_ff && in_ready) begin
            buf_ff[wr_ptr_ff] <= word_ff;
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         fill_ff <= fill_ff + 2'(push_ff && in_ready) - 2'(pop);
      end
   end

   // Self-timed core: runs regardless of select or hold
   wr_word_t cur;
   logic     bad;
   always_comb begin
      cur = buf_ff[rd_ptr_ff];
      bad = ~wp_sync_ff[1] & (cur.kind != OP_OTP_PROG);
      if (cur.kind == OP_OTP_PROG) begin
         bad = lock_ff | (cur.addr[6] == 1'b0) | (cur.addr >= ADDR_W'(OTP_BYTES));
      end
      if (cur.addr >= ADDR_W'(ARRAY_BYTES) && cur.kind != OP_ERASE_ALL) begin
         bad = 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy_ff <= BUSY_RST;
         fail_ff <= 1'b0;
         lock_ff <= 1'b0;
      end else if (pop) begin
         busy_ff <= 16'(BUSY_CYC);
         fail_ff <= bad;
         lock_ff <= lock_ff | ((cur.kind == OP_OTP_PROG) & ~bad);
      end else if (busy_ff != BUSY_RST) begin
         busy_ff <= busy_ff - 16'h0001;
      end
   end
   assign busy = (busy_ff != BUSY_RST) | out_valid;
   assign op_fail = fail_ff;

   busy_len_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pop |=> busy [*8]) else $error("busy dropped early");
   float_sel_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      device_select_n |-> !dual_io_1_oe && !dual_io_0_oe)
      else $error("output driven while deselected");
   dual_oe_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      dual_io_0_oe |-> dual_io_1_oe) else $error("io0 driven alone");
   fill_lim_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      fill_ff <= 2'h2) else $error("buffer overfilled");
   hold_float_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!hold_n && !sck) |-> !dual_io_1_oe) else $error("driven in hold");
   wp_fail_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pop && !wp_sync_ff[1] && cur.kind == OP_PROGRAM) |=> op_fail)
      else $error("protect not reported");
   otp_fail_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pop && cur.kind == OP_OTP_PROG && !cur.addr[6]) |=> op_fail)
      else $error("factory area written");
   busy_end_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $fell(busy) |-> $past(busy_ff) == 16'h0001 || !$past(out_valid))
      else $error("busy ended mid cycle");
endmodule

/* File: bench/spi_host_model.sv */
/*
 Host model for the serial front end: drives select, SCK, hold and serial in.
 Assumes the bench resolves the shared data lines from both enables.
*/
`timescale 1ns/1ps
module spi_host_model (
   output logic      sck,      // Link clock, stands still outside frames except in wiggle and when start sets it to cpol
   output logic      cs_n,     // Select, active low
   output logic      hold_n,   // Pause, active low
   output logic      si,       // Serial in value
   input  wire logic so_line,  // Resolved io1 level
   input  wire logic io0_line  // Resolved io0 level
);
   logic cpol;  // Idle level: 0 for mode 0, 1 for mode 3

   // Idle state, deselected
   initial begin
      cpol = 1'b0;
      sck = 1'b0;
      cs_n = 1'b1;
      hold_n = 1'b1;
      si = 1'b0;
   end

   // Odd offset keeps SCK off the system clock grid
   task automatic start();
      sck = cpol;
      #3.3 cs_n = 1'b0;
      #40 sck = 1'b0;
      #40;
   endtask

   // One byte out, most significant bit first
   task automatic send(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         si = v[i];
         #80 sck = 1'b1;
         #80 sck = 1'b0;
      end
   endtask

   // One byte in; sampled on the rise after the device's falling edge
   task automatic recv(input bit dual, output logic [7:0] v);
      for (int i = 7; i >= 0; i -= (dual ? 2 : 1)) begin
         si = ~si;  // Released line keeps changing
         #80 sck = 1'b1;
         if (dual) v[i -: 2] = {so_line, io0_line};
         else v[i] = so_line;
         #80 sck = 1'b0;
      end
   endtask

   // End of frame, SCK back to its idle level first
   task automatic stop();
      #40 sck = cpol;
      #40 cs_n = 1'b1;
      #160;
   endtask

   // Hold begins with SCK low and select low; one edge must be ignored
   task automatic pause();
      hold_n = 1'b0;
      #80 sck = 1'b1;
      si = ~si;
      #80 sck = 1'b0;
      #80;
   endtask

   task automatic resume();
      hold_n = 1'b1;
      #80;
   endtask

   // Serial in and SCK toggle while deselected; nothing may be taken
   task automatic wiggle();
      repeat (8) begin
         #37 si = ~si;
         #40 sck = ~sck;
      end
   endtask
endmodule

/* File: bench/spi_flash_serial_front_end_tb_top.sv */
/*
 Self-checking bench for the serial flash front end.
 Assumes the host model of spi_host_model.sv and the shared package.
*/
`timescale 1ns/1ps
module spi_flash_serial_front_end_tb_top;
   import flash_fe_pkg::*;
   logic      clk_sys = 1'b0;
   logic      arst_n = 1'b0;
   logic      write_protect_n = 1'b1;
   wire logic sck;
   wire logic device_select_n;
   wire logic hold_n;
   wire logic si;
   logic      io0_o;
   logic      io0_oe;
   logic      io1_o;
   logic      io1_oe;
   logic      busy;
   logic      op_fail;
   int        err_count = 0;
   int        total_checks = 0;
   int        cyc = 0;
   logic [7:0] v;
   // Undriven lines show a changing pattern, not a held value
   wire logic io0_line = io0_oe ? io0_o : si;
   wire logic so_line = io1_oe ? io1_o : ~si;

   initial forever #4 clk_sys = ~clk_sys;

   flash_fe DUT (.clk_sys(clk_sys), .arst_n(arst_n), .sck(sck),
      .device_select_n(device_select_n), .hold_n(hold_n),
      .write_protect_n(write_protect_n), .dual_io_0_i(io0_line),
      .dual_io_0_o(io0_o), .dual_io_0_oe(io0_oe), .dual_io_1_o(io1_o),
      .dual_io_1_oe(io1_oe), .busy(busy), .op_fail(op_fail));

   spi_host_model host (.sck(sck), .cs_n(device_select_n), .hold_n(hold_n),
      .si(si), .so_line(so_line), .io0_line(io0_line));

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Hang guard; the whole run needs about 11000 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         end_sim();
      end
   end

   // Mode: 0 cmd only, 1 +addr, 2 +addr+byte a[31:24], 3/4 read, 5 status
   task automatic frame(input logic [7:0] cmd, input logic [31:0] a, input int m);
      host.start();
      host.send(cmd);
      if (m inside {[1:4]}) for (int k = 2; k >= 0; k--) host.send(a[k*8 +: 8]);
      if (m == 2) host.send(a[31:24]);
      if (m >= 3) host.recv(m == 4, v);
      host.stop();
   endtask

   // Busy must still stand after select rises, then clear within bound
   task automatic wait_core(input logic fail_exp);
      int n;
      n = 0;
      @(negedge clk_sys);
      chk("busy after select rise", 8'h01, {7'h00, busy});
      while (busy !== 1'b0 && n < 600) begin
         @(negedge clk_sys);
         n++;
      end
      chk("busy cleared", 8'h00, {7'h00, busy});
      chk("op_fail", {7'h00, fail_exp}, {7'h00, op_fail});
   endtask

   task automatic t_idle();
      host.wiggle();
      chk("io1 enable deselected", 8'h00, {7'h00, io1_oe});
      chk("io0 enable deselected", 8'h00, {7'h00, io0_oe});
      chk("busy deselected", 8'h00, {7'h00, busy});
      $display("test idle done");
   endtask

   // Mode 0 and mode 3 single reads, address low byte comes back
   task automatic t_read();
      logic [31:0] a;
      for (int m = 0; m < 2; m++) begin
         host.cpol = m[0];
         a = m ? 32'h0000_005A : 32'h0012_34A5;
         frame(CMD_READ, a, 3);
         chk("read byte", a[7:0], v);
         chk("io1 enable after frame", 8'h00, {7'h00, io1_oe});
      end
      host.cpol = 1'b0;
      $display("test read done");
   endtask

   task automatic t_dual();
      frame(CMD_DUAL_READ, 32'h0000_00C3, 4);
      chk("dual read byte", 8'hC3, v);
      chk("io0 enable after frame", 8'h00, {7'h00, io0_oe});
      $display("test dual done");
   endtask

   // Hold between address and data; the edge under hold is dropped
   task automatic t_hold();
      host.start();
      host.send(CMD_READ);
      host.send(8'h00);
      host.send(8'h00);
      host.send(8'h96);
      host.pause();
      chk("io1 enable held", 8'h00, {7'h00, io1_oe});
      host.resume();
      host.recv(1'b0, v);
      host.stop();
      chk("read after hold", 8'h96, v);
      $display("test hold done");
   endtask

   task automatic t_prog();
      frame(CMD_PROGRAM, 32'h3C00_0010, 2);
      wait_core(1'b0);
      @(posedge clk_sys) write_protect_n <= 1'b0;
      frame(CMD_PROGRAM, 32'h3C00_0010, 2);
      wait_core(1'b1);
      frame(CMD_STATUS, 32'h0000_0000, 5);
      chk("status byte", 8'h01, v);
      @(posedge clk_sys) write_protect_n <= 1'b1;
      $display("test program done");
   endtask

   task automatic t_erase();
      logic [7:0] codes [4];
      codes = '{CMD_ERASE_PG, CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_ALL};
      for (int k = 0; k < 4; k++) begin
         frame(codes[k], 32'h0000_1000, (k == 3) ? 0 : 1);
         wait_core(1'b0);
      end
      $display("test erase done");
   endtask

   // Factory half reads back; user half takes one program only
   task automatic t_otp();
      frame(CMD_OTP_READ, 32'h0000_0025, 3);
      chk("otp factory byte", 8'h25, v);
      frame(CMD_OTP_PROG, 32'hA500_0040, 2);
      wait_core(1'b0);
      frame(CMD_OTP_PROG, 32'hA500_0040, 2);
      wait_core(1'b1);
      $display("test otp done");
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_idle();
      t_read();
      t_dual();
      t_hold();
      t_prog();
      t_erase();
      t_otp();
      end_sim();
   end
endmodule
